/* File: logic/camd_addr_decoder.v */
// Purpose: Operand fetch and effective-address unit of an 8-bit core.
// Assumes: Read data stands in the cycle in which mem_rd_r is high.
// Notes:   One instruction at a time; start is ignored while busy.
`include "camd_defines.vh"

module camd_addr_decoder (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        start,
  input  wire [3:0]  mode,
  input  wire [2:0]  op_class,
  input  wire        pfx_present,
  input  wire [7:0]  pfx,
  input  wire [3:0]  cond,
  input  wire [2:0]  bit_sel,
  input  wire        bit_jump_if_set,
  input  wire [15:0] pc_in,
  input  wire [7:0]  x_in,
  input  wire [7:0]  y_in,
  input  wire [7:0]  acc_in,
  input  wire        flag_n,
  input  wire        flag_z,
  input  wire        flag_c,
  input  wire        flag_h,
  input  wire        flag_i1,
  input  wire        flag_i0,
  input  wire        int_pin,
  input  wire [7:0]  mem_rdata,
  output reg         mem_rd_r,
  output reg  [15:0] mem_addr_r,
  output reg         busy_r,
  output reg         done_r,
  output reg         form_err_r,
  output reg  [15:0] ea_r,
  output reg  [1:0]  extra_bytes_r,
  output reg  [15:0] next_pc_r,
  output reg         taken_r,
  output reg         use_y_r,
  output reg         indirect_r,
  output reg         nz_wr_r,
  output reg         n_out_r,
  output reg         z_out_r,
  output reg         carry_wr_r,
  output reg         carry_out_r
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_B1   = 3'h1;
  localparam [2:0] S_B2   = 3'h2;
  localparam [2:0] S_P1   = 3'h3;
  localparam [2:0] S_P2   = 3'h4;
  localparam [2:0] S_EA   = 3'h5;
  localparam [2:0] S_OPND = 3'h6;

  reg  [2:0]  state_r;
  reg  [3:0]  mode_r;
  reg  [2:0]  cls_r;
  reg  [3:0]  cond_r;
  reg  [2:0]  bsel_r;
  reg         bset_r;
  reg         word_r;
  reg  [15:0] pc_r;
  reg  [7:0]  idx_r;
  reg  [7:0]  acc_r;
  reg  [7:0]  b1_r;
  reg  [7:0]  b2_r;
  reg  [15:0] ptr_r;

  reg         d_ind;
  reg         d_usey;
  reg         d_err;
  reg  [1:0]  d_xb;
  reg  [15:0] base_nxt;
  reg  [15:0] ea_nxt;
  reg  [7:0]  off_nxt;
  reg  [7:0]  opnd_and;

  wire m_long = (mode == `CAMD_M_DIRL) || (mode == `CAMD_M_IDXL);
  wire m_idx  = (mode == `CAMD_M_IDXS) || (mode == `CAMD_M_IDXL);
  wire c_jump = (op_class == `CAMD_C_JRC) || (op_class == `CAMD_C_CALR);
  wire c_shrt = (op_class == `CAMD_C_SHORT) || (op_class == `CAMD_C_BTJ);

  wire r_long = (mode_r == `CAMD_M_DIRL) || (mode_r == `CAMD_M_IDXL);
  wire r_idx  = (mode_r == `CAMD_M_IDX0) || (mode_r == `CAMD_M_IDXS) ||
                (mode_r == `CAMD_M_IDXL);
  wire r_btj  = (mode_r == `CAMD_M_BITR);
  wire r_rel  = (mode_r == `CAMD_M_REL);
  wire r_rd   = (cls_r == `CAMD_C_BTA) || (cls_r == `CAMD_C_BTJ);

  wire [15:0] pc_after = pc_r + 16'h0001 + {14'h0000, extra_bytes_r};

  function cond_ok;
    input [3:0] c;
    begin
      case (c)
        `CAMD_J_ALW:  cond_ok = 1'b1;
        `CAMD_J_NEV:  cond_ok = 1'b0;
        `CAMD_J_NEG:  cond_ok = flag_n;
        `CAMD_J_POS:  cond_ok = ~flag_n;
        `CAMD_J_ZER:  cond_ok = flag_z;
        `CAMD_J_NZR:  cond_ok = ~flag_z;
        `CAMD_J_CS:   cond_ok = flag_c;
        `CAMD_J_CC:   cond_ok = ~flag_c;
        `CAMD_J_HS:   cond_ok = flag_h;
        `CAMD_J_HC:   cond_ok = ~flag_h;
        `CAMD_J_MSK:  cond_ok = flag_i1 & flag_i0;
        `CAMD_J_UMSK: cond_ok = ~(flag_i1 & flag_i0);
        `CAMD_J_ULE:  cond_ok = flag_c | flag_z;
        `CAMD_J_UGT:  cond_ok = ~(flag_c | flag_z);
        `CAMD_J_INTH: cond_ok = int_pin;
        `CAMD_J_INTL: cond_ok = ~int_pin;
        default:      cond_ok = 1'b0;
      endcase
    end
  endfunction

  // Prefix, class and mode checks, and byte count after the opcode.
  always @* begin
    d_ind  = 1'b0;
    d_usey = 1'b0;
    d_err  = 1'b0;
    if (pfx_present) begin
      case (pfx)
        `CAMD_PFX_Y: begin
          d_usey = 1'b1;
          if (mode > `CAMD_M_IDXL)
            d_err = 1'b1;
        end
        `CAMD_PFX_IND: begin
          d_ind = 1'b1;
          if ((mode == `CAMD_M_INH) || (mode == `CAMD_M_IMM) ||
              (mode == `CAMD_M_IDX0))
            d_err = 1'b1;
        end
        `CAMD_PFX_YI: begin
          d_ind  = 1'b1;
          d_usey = 1'b1;
          if (!m_idx)
            d_err = 1'b1;
        end
        default: d_err = 1'b1;
      endcase
    end
    if (m_long && c_shrt)
      d_err = 1'b1;
    if ((mode == `CAMD_M_IMM) && c_shrt)
      d_err = 1'b1;
    if ((mode == `CAMD_M_REL) != c_jump)
      d_err = 1'b1;
    if ((mode == `CAMD_M_BITR) != (op_class == `CAMD_C_BTJ))
      d_err = 1'b1;
    if ((mode == `CAMD_M_BITD) && (op_class != `CAMD_C_SHORT))
      d_err = 1'b1;
    if (mode > `CAMD_M_BITR)
      d_err = 1'b1;
    case (mode)
      `CAMD_M_INH:  d_xb = 2'd0;
      `CAMD_M_IDX0: d_xb = 2'd0;
      `CAMD_M_DIRL: d_xb = d_ind ? 2'd1 : 2'd2;
      `CAMD_M_IDXL: d_xb = d_ind ? 2'd1 : 2'd2;
      `CAMD_M_BITR: d_xb = 2'd2;
      default:      d_xb = 2'd1;
    endcase
  end

  // Effective address from the collected bytes and pointer.
  always @* begin
    if (mode_r == `CAMD_M_IMM)
      base_nxt = pc_r + 16'h0001;
    else if (mode_r == `CAMD_M_IDX0)
      base_nxt = `CAMD_RST_ADDR;
    else if (indirect_r)
      base_nxt = ptr_r;
    else if (r_long)
      base_nxt = {b1_r, b2_r};
    else
      base_nxt = {`CAMD_PAGE0, b1_r};
    if (r_idx)
      ea_nxt = base_nxt + {8'h00, idx_r};
    else
      ea_nxt = base_nxt;
    if (r_btj)
      off_nxt = b2_r;
    else if (indirect_r)
      off_nxt = ptr_r[7:0];
    else
      off_nxt = b1_r;
    opnd_and = acc_r & mem_rdata;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r       <= S_IDLE;
      mode_r        <= `CAMD_M_INH;
      cls_r         <= `CAMD_C_LONG;
      cond_r        <= `CAMD_J_NEV;
      bsel_r        <= 3'h0;
      bset_r        <= 1'b0;
      word_r        <= 1'b0;
      pc_r          <= `CAMD_RST_ADDR;
      idx_r         <= `CAMD_RST_BYTE;
      acc_r         <= `CAMD_RST_BYTE;
      b1_r          <= `CAMD_RST_BYTE;
      b2_r          <= `CAMD_RST_BYTE;
      ptr_r         <= `CAMD_RST_ADDR;
      mem_rd_r      <= 1'b0;
      mem_addr_r    <= `CAMD_RST_ADDR;
      busy_r        <= 1'b0;
      done_r        <= 1'b0;
      form_err_r    <= 1'b0;
      ea_r          <= `CAMD_RST_ADDR;
      extra_bytes_r <= 2'd0;
      next_pc_r     <= `CAMD_RST_ADDR;
      taken_r       <= 1'b0;
      use_y_r       <= 1'b0;
      indirect_r    <= 1'b0;
      nz_wr_r       <= 1'b0;
      n_out_r       <= 1'b0;
      z_out_r       <= 1'b0;
      carry_wr_r    <= 1'b0;
      carry_out_r   <= 1'b0;
    end else begin
      mem_rd_r   <= 1'b0;
      done_r     <= 1'b0;
      nz_wr_r    <= 1'b0;
      carry_wr_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            mode_r        <= mode;
            cls_r         <= op_class;
            cond_r        <= cond;
            bsel_r        <= bit_sel;
            bset_r        <= bit_jump_if_set;
            pc_r          <= pc_in;
            acc_r         <= acc_in;
            idx_r         <= d_usey ? y_in : x_in;
            use_y_r       <= d_usey;
            indirect_r    <= d_ind;
            word_r        <= d_ind & m_long;
            extra_bytes_r <= d_xb;
            taken_r       <= 1'b0;
            form_err_r    <= d_err;
            if (d_err) begin
              done_r    <= 1'b1;
              next_pc_r <= pc_in + 16'h0001;
            end else if (d_xb != 2'd0) begin
              busy_r     <= 1'b1;
              mem_rd_r   <= 1'b1;
              mem_addr_r <= pc_in + 16'h0001;
              state_r    <= S_B1;
            end else begin
              busy_r  <= 1'b1;
              state_r <= S_EA;
            end
          end
        end
        S_B1: begin
          b1_r <= mem_rdata;
          if (extra_bytes_r == 2'd2) begin
            mem_rd_r   <= 1'b1;
            mem_addr_r <= pc_r + 16'h0002;
            state_r    <= S_B2;
          end else if (indirect_r) begin
            mem_rd_r   <= 1'b1;
            mem_addr_r <= {`CAMD_PAGE0, mem_rdata};
            state_r    <= S_P1;
          end else begin
            state_r <= S_EA;
          end
        end
        S_B2: begin
          b2_r <= mem_rdata;
          if (indirect_r) begin
            mem_rd_r   <= 1'b1;
            mem_addr_r <= {`CAMD_PAGE0, b1_r};
            state_r    <= S_P1;
          end else begin
            state_r <= S_EA;
          end
        end
        S_P1: begin
          if (word_r) begin
            ptr_r[15:8] <= mem_rdata;
            mem_rd_r    <= 1'b1;
            mem_addr_r  <= {`CAMD_PAGE0, b1_r} + 16'h0001;
            state_r     <= S_P2;
          end else begin
            ptr_r   <= {`CAMD_PAGE0, mem_rdata};
            state_r <= S_EA;
          end
        end
        S_P2: begin
          ptr_r[7:0] <= mem_rdata;
          state_r    <= S_EA;
        end
        S_EA: begin
          ea_r <= ea_nxt;
          if (r_rel) begin
            taken_r   <= cond_ok(cond_r) | (cls_r == `CAMD_C_CALR);
            if (cond_ok(cond_r) || (cls_r == `CAMD_C_CALR))
              next_pc_r <= pc_after + {{8{off_nxt[7]}}, off_nxt};
            else
              next_pc_r <= pc_after;
            busy_r    <= 1'b0;
            done_r    <= 1'b1;
            state_r   <= S_IDLE;
          end else if (r_rd) begin
            mem_rd_r   <= 1'b1;
            mem_addr_r <= ea_nxt;
            state_r    <= S_OPND;
          end else begin
            next_pc_r <= pc_after;
            busy_r    <= 1'b0;
            done_r    <= 1'b1;
            state_r   <= S_IDLE;
          end
        end
        S_OPND: begin
          if (cls_r == `CAMD_C_BTA) begin
            nz_wr_r   <= 1'b1;
            n_out_r   <= opnd_and[7];
            z_out_r   <= (opnd_and == 8'h00);
            next_pc_r <= pc_after;
          end else begin
            carry_wr_r  <= 1'b1;
            carry_out_r <= mem_rdata[bsel_r];
            taken_r     <= mem_rdata[bsel_r] == bset_r;
            if (mem_rdata[bsel_r] == bset_r)
              next_pc_r <= pc_after + {{8{off_nxt[7]}}, off_nxt};
            else
              next_pc_r <= pc_after;
          end
          busy_r  <= 1'b0;
          done_r  <= 1'b1;
          state_r <= S_IDLE;
        end
        default: begin
          busy_r  <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // camd_addr_decoder

/* File: logic/camd_defines.vh */
// Purpose: Constants for the addressing-mode decoder.
// Assumes: Included by bare name from the decoder source.
// Notes:   Definitions only.
`ifndef CAMD_DEFINES_VH
`define CAMD_DEFINES_VH

// Base addressing modes, as given by the opcode before any prefix.
`define CAMD_M_INH   4'h0
`define CAMD_M_IMM   4'h1
`define CAMD_M_DIRS  4'h2
`define CAMD_M_DIRL  4'h3
`define CAMD_M_IDX0  4'h4
`define CAMD_M_IDXS  4'h5
`define CAMD_M_IDXL  4'h6
`define CAMD_M_REL   4'h7
`define CAMD_M_BITD  4'h8
`define CAMD_M_BITR  4'h9

// Instruction classes.
`define CAMD_C_LONG  3'h0
`define CAMD_C_BTA   3'h1
`define CAMD_C_SHORT 3'h2
`define CAMD_C_BTJ   3'h3
`define CAMD_C_JRC   3'h4
`define CAMD_C_CALR  3'h5

// Prefix byte values.
`define CAMD_PFX_Y   8'h90
`define CAMD_PFX_IND 8'h92
`define CAMD_PFX_YI  8'h91

// Jump condition codes.
`define CAMD_J_ALW   4'h0
`define CAMD_J_NEV   4'h1
`define CAMD_J_NEG   4'h2
`define CAMD_J_POS   4'h3
`define CAMD_J_ZER   4'h4
`define CAMD_J_NZR   4'h5
`define CAMD_J_CS    4'h6
`define CAMD_J_CC    4'h7
`define CAMD_J_HS    4'h8
`define CAMD_J_HC    4'h9
`define CAMD_J_MSK   4'hA
`define CAMD_J_UMSK  4'hB
`define CAMD_J_ULE   4'hC
`define CAMD_J_UGT   4'hD
`define CAMD_J_INTH  4'hE
`define CAMD_J_INTL  4'hF

// Reset values, and the high address byte of page zero.
`define CAMD_RST_ADDR 16'h0000
`define CAMD_RST_BYTE 8'h00
`define CAMD_PAGE0    8'h00

`endif

/* File: verif/camd_mem_model.sv */
// Purpose: Byte-wide program and data memory in front of the decoder.
// Assumes: The bench loads bytes straight into mem before each start.
// Notes:   Read data follows the address while the strobe is high.
module camd_mem_model (
  input  logic        mem_rd_r,
  input  logic [15:0] mem_addr_r,
  output logic [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // Outside a read cycle the byte is inverted, so stale data never passes.
  assign mem_rdata = mem_rd_r ? mem[mem_addr_r] : ~mem[mem_addr_r];
endmodule // camd_mem_model

/* File: verif/camd_addr_chk.sv */
// Purpose: Port protocol checks for the addressing-mode decoder.
// Assumes: Inputs stay stable while an instruction is in flight.
// Notes:   Bound to every instance of the decoder.
module camd_addr_chk (
  input logic       core_clk,
  input logic       rst,
  input logic       start,
  input logic       bit_jump_if_set,
  input logic       mem_rd_r,
  input logic       busy_r,
  input logic       done_r,
  input logic       form_err_r,
  input logic [1:0] extra_bytes_r,
  input logic       taken_r,
  input logic       nz_wr_r,
  input logic       n_out_r,
  input logic       z_out_r,
  input logic       carry_wr_r,
  input logic       carry_out_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    start && !busy_r;
  endsequence
  take_ack_a: assert property (s_take |=> busy_r || done_r)
    else $error("start was not taken");
  done_bound_a: assert property (s_take |-> ##[1:6] done_r)
    else $error("no done within six cycles");
  done_idle_a: assert property (done_r |-> !busy_r && !mem_rd_r)
    else $error("busy or reading at done");
  read_busy_a: assert property (mem_rd_r |-> busy_r)
    else $error("read strobe while idle");
  extra_max_a: assert property (done_r |-> extra_bytes_r != 2'h3)
    else $error("more than two extra bytes");
  err_noread_a: assert property (done_r && form_err_r |->
    !$past(mem_rd_r)) else $error("memory read on refused form");
  nz_pair_a: assert property (nz_wr_r |-> done_r && !(n_out_r && z_out_r))
    else $error("bad flag write");
  bit_jump_a: assert property (carry_wr_r |-> done_r &&
    taken_r == (carry_out_r == bit_jump_if_set)) else $error("bit jump");
endmodule // camd_addr_chk
bind camd_addr_decoder camd_addr_chk camd_addr_chk_i (
  .core_clk(core_clk), .rst(rst), .start(start), .mem_rd_r(mem_rd_r),
  .bit_jump_if_set(bit_jump_if_set), .busy_r(busy_r), .done_r(done_r),
  .form_err_r(form_err_r), .extra_bytes_r(extra_bytes_r), .taken_r(taken_r),
  .nz_wr_r(nz_wr_r), .n_out_r(n_out_r), .z_out_r(z_out_r),
  .carry_wr_r(carry_wr_r), .carry_out_r(carry_out_r));

/* File: verif/cpu_addressing_mode_decoder_test.sv */
// Purpose: Self-checking bench for the addressing-mode decoder.
// Assumes: Inputs change on the falling edge and hold until done.
// Notes:   Expected results queue up and are popped at each done.
`include "camd_defines.vh"
module cpu_addressing_mode_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic er; logic [15:0] ea; logic [1:0] xb; logic [15:0] np;
    logic j; logic tk; logic w; logic [1:0] nz; logic cw; logic cy;
    logic y; logic i;
  } camd_exp_t;
  logic core_clk = 0, rst = 1, start = 0, pfx_present = 0;
  logic bit_jump_if_set = 0, flag_n = 0, flag_z = 0, flag_c = 0;
  logic flag_h = 0, flag_i1 = 0, flag_i0 = 0, int_pin = 0;
  logic [3:0] mode = 0, cond = 0;
  logic [2:0] op_class = 0, bit_sel = 0;
  logic [7:0] pfx = 0, x_in = 0, y_in = 0, acc_in = 0, b1, b2, p, o;
  logic [15:0] pc_in = 0, pc;
  wire [7:0] mem_rdata;
  wire [15:0] mem_addr_r, ea_r, next_pc_r;
  wire [1:0] extra_bytes_r;
  wire mem_rd_r, busy_r, done_r, form_err_r, taken_r, use_y_r, indirect_r;
  wire nz_wr_r, n_out_r, z_out_r, carry_wr_r, carry_out_r;
  int fail_count = 0, n_compared = 0, cyc = 0, k;
  camd_exp_t q[$], me, e;
  always #12.5 core_clk = ~core_clk;
  camd_addr_decoder camd_addr_decoder_i (.core_clk(core_clk), .rst(rst),
    .start(start), .mode(mode), .op_class(op_class), .pfx(pfx),
    .pfx_present(pfx_present), .cond(cond), .bit_sel(bit_sel),
    .bit_jump_if_set(bit_jump_if_set), .pc_in(pc_in), .x_in(x_in),
    .y_in(y_in), .acc_in(acc_in), .flag_n(flag_n), .flag_z(flag_z),
    .flag_c(flag_c), .flag_h(flag_h), .flag_i1(flag_i1), .flag_i0(flag_i0),
    .int_pin(int_pin), .mem_rdata(mem_rdata), .mem_rd_r(mem_rd_r),
    .mem_addr_r(mem_addr_r), .busy_r(busy_r), .done_r(done_r),
    .form_err_r(form_err_r), .ea_r(ea_r), .extra_bytes_r(extra_bytes_r),
    .next_pc_r(next_pc_r), .taken_r(taken_r), .use_y_r(use_y_r),
    .indirect_r(indirect_r),
    .nz_wr_r(nz_wr_r), .n_out_r(n_out_r), .z_out_r(z_out_r),
    .carry_wr_r(carry_wr_r), .carry_out_r(carry_out_r));
  camd_mem_model camd_mem_model_i (.mem_rd_r(mem_rd_r),
    .mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata));
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function logic [15:0] sx(input logic [7:0] v);
    sx = {{8{v[7]}}, v};
  endfunction
  function camd_exp_t mk(input logic [15:0] ea, input logic [1:0] xb,
                         input logic [15:0] np, input logic er);
    mk = '0;
    mk.ea = ea;
    mk.xb = xb;
    mk.np = np;
    mk.er = er;
  endfunction
  function logic cj(input logic [3:0] c);
    case (c)
      4'h0: cj = 1'b1;
      4'h1: cj = 1'b0;
      4'h2: cj = flag_n;
      4'h3: cj = !flag_n;
      4'h4: cj = flag_z;
      4'h5: cj = !flag_z;
      4'h6: cj = flag_c;
      4'h7: cj = !flag_c;
      4'h8: cj = flag_h;
      4'h9: cj = !flag_h;
      4'hA: cj = flag_i1 & flag_i0;
      4'hB: cj = !(flag_i1 & flag_i0);
      4'hC: cj = flag_c | flag_z;
      4'hD: cj = !(flag_c | flag_z);
      4'hE: cj = int_pin;
      default: cj = !int_pin;
    endcase
  endfunction
  // Random operand bytes; p sits at page-zero address b1, o just after.
  task rnd;
    pc = 16'h8000 | 16'($urandom & 32'h7FF0);
    {b1, b2, p, o} = $urandom;
    {x_in, y_in, acc_in, bit_sel} = 27'($urandom);
    {flag_n, flag_z, flag_c, flag_h, flag_i1, flag_i0, int_pin} = 7'($urandom);
    camd_mem_model_i.mem[pc + 16'h0001] = b1;
    camd_mem_model_i.mem[pc + 16'h0002] = b2;
    camd_mem_model_i.mem[{8'h00, b1}] = p;
    camd_mem_model_i.mem[{8'h00, b1} + 16'h0001] = o;
  endtask
  task go(input logic [3:0] m, input logic [2:0] c, input logic [7:0] pf,
          input camd_exp_t ex);
    int n;
    ex.y = (pf == `CAMD_PFX_Y) || (pf == `CAMD_PFX_YI);
    ex.i = (pf == `CAMD_PFX_IND) || (pf == `CAMD_PFX_YI);
    q.push_back(ex);
    @(negedge core_clk);
    {mode, op_class, pfx, pfx_present, pc_in, start} = {m, c, pf, pf != 0, pc, 1'b1};
    @(negedge core_clk);
    start = 0;
    for (n = 0; n < 10 && done_r !== 1'b1; n++) @(negedge core_clk);
    if (n == 10) chk(16'h0000, 16'h0001);
    $display("test mode %h class %h prefix %h ended", m, c, pf);
  endtask
  always @(negedge core_clk) begin
    if (done_r === 1'b1 && q.size() > 0) begin
      me = q.pop_front();
      chk(form_err_r, me.er);
      chk(next_pc_r, me.np);
      if (!me.er) begin
        chk(extra_bytes_r, me.xb);
        chk(use_y_r, me.y);
        chk(indirect_r, me.i);
        if (me.j) chk(taken_r, me.tk);
        else chk(ea_r, me.ea);
        chk(nz_wr_r, me.w);
        if (me.w) chk({n_out_r, z_out_r}, me.nz);
        chk(carry_wr_r, me.cw);
        if (me.cw) chk(carry_out_r, me.cy);
      end
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 4000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(3));
    repeat (16) @(negedge core_clk);
    rst = 0;
    rnd; go(`CAMD_M_DIRS, `CAMD_C_LONG, 0, mk({8'h00, b1}, 1, pc + 16'h0002, 0));
    rnd; go(`CAMD_M_DIRL, `CAMD_C_LONG, 0, mk({b1, b2}, 2, pc + 16'h0003, 0));
    rnd; go(`CAMD_M_IDX0, `CAMD_C_SHORT, 0, mk({8'h00, x_in}, 0, pc + 16'h0001, 0));
    rnd; go(`CAMD_M_IDX0, `CAMD_C_LONG, `CAMD_PFX_Y, mk({8'h00, y_in}, 0, pc + 16'h0001, 0));
    rnd; x_in = 8'hFF;
    camd_mem_model_i.mem[pc + 16'h0001] = 8'hFF;
    go(`CAMD_M_IDXS, `CAMD_C_LONG, 0, mk(16'h01FE, 1, pc + 16'h0002, 0));
    rnd; go(`CAMD_M_IDXL, `CAMD_C_LONG, `CAMD_PFX_Y, mk({b1, b2} + y_in, 2, pc + 16'h0003, 0));
    rnd; go(`CAMD_M_DIRS, `CAMD_C_SHORT, `CAMD_PFX_IND, mk({8'h00, p}, 1, pc + 16'h0002, 0));
    rnd; go(`CAMD_M_DIRL, `CAMD_C_LONG, `CAMD_PFX_IND, mk({p, o}, 1, pc + 16'h0002, 0));
    rnd; go(`CAMD_M_IDXS, `CAMD_C_LONG, `CAMD_PFX_IND, mk({8'h00, p} + x_in, 1, pc + 16'h0002, 0));
    rnd; go(`CAMD_M_IDXS, `CAMD_C_LONG, `CAMD_PFX_YI, mk({8'h00, p} + y_in, 1, pc + 16'h0002, 0));
    rnd; go(`CAMD_M_DIRS, `CAMD_C_LONG, 8'h93, mk(0, 0, pc + 16'h0001, 1));
    rnd; go(`CAMD_M_DIRL, `CAMD_C_SHORT, 0, mk(0, 0, pc + 16'h0001, 1));
    rnd; go(`CAMD_M_IDXL, `CAMD_C_BTJ, 0, mk(0, 0, pc + 16'h0001, 1));
    for (k = 0; k < 18; k++) begin
      rnd;
      cond = k[3:0];
      e = mk(0, 1, pc + 16'h0002, 0);
      e.j = 1;
      e.tk = (k > 15) || cj(cond);
      if (k == 16) e.np = pc + 16'h0002 + sx(p);
      else if (e.tk) e.np = e.np + sx(b1);
      if (k < 16) go(`CAMD_M_REL, `CAMD_C_JRC, 0, e);
      else if (k == 16) go(`CAMD_M_REL, `CAMD_C_JRC, `CAMD_PFX_IND, e);
      else go(`CAMD_M_REL, `CAMD_C_CALR, 0, e);
    end
    for (k = 0; k < 2; k++) begin
      rnd;
      if (k == 0) acc_in = ~p;
      e = mk({8'h00, b1}, 1, pc + 16'h0002, 0);
      e.w = 1;
      e.nz = {acc_in[7] & p[7], (acc_in & p) == 8'h00};
      go(`CAMD_M_DIRS, `CAMD_C_BTA, 0, e);
      rnd;
      bit_jump_if_set = k[0];
      e = mk(0, 2, pc + 16'h0003, 0);
      {e.j, e.cw, e.cy} = {2'h3, p[bit_sel]};
      e.tk = p[bit_sel] == k[0];
      if (e.tk) e.np = e.np + sx(b2);
      go(`CAMD_M_BITR, `CAMD_C_BTJ, 0, e);
    end
    rnd; e = mk(pc + 16'h0001, 1, pc + 16'h0002, 0);
    go(`CAMD_M_IMM, `CAMD_C_LONG, 0, e);
    e = mk({8'h00, b1}, 1, pc + 16'h0002, 0);
    go(`CAMD_M_BITD, `CAMD_C_SHORT, 0, e);
    e = mk({8'h00, p}, 1, pc + 16'h0002, 0);
    go(`CAMD_M_BITD, `CAMD_C_SHORT, `CAMD_PFX_IND, e);
    e = mk({p, o} + x_in, 1, pc + 16'h0002, 0);
    go(`CAMD_M_IDXL, `CAMD_C_LONG, `CAMD_PFX_IND, e);
    e = mk({p, o} + y_in, 1, pc + 16'h0002, 0);
    go(`CAMD_M_IDXL, `CAMD_C_LONG, `CAMD_PFX_YI, e);
    e = mk(0, 0, pc + 16'h0001, 0);
    e.j = 1;
    go(`CAMD_M_INH, `CAMD_C_LONG, `CAMD_PFX_Y, e);
    e = mk(0, 0, pc + 16'h0001, 1);
    go(`CAMD_M_REL, `CAMD_C_JRC, `CAMD_PFX_Y, e);
    go(`CAMD_M_IMM, `CAMD_C_LONG, `CAMD_PFX_IND, e);
    go(`CAMD_M_DIRS, `CAMD_C_LONG, `CAMD_PFX_YI, e);
    rnd; bit_jump_if_set = o[0];
    p = b1 ^ 8'h80;
    camd_mem_model_i.mem[{8'h00, b1}] = p;
    camd_mem_model_i.mem[{8'h00, p}] = o;
    e = mk(0, 2, pc + 16'h0003, 0);
    {e.j, e.cw, e.cy} = {2'h3, o[bit_sel]};
    e.tk = o[bit_sel] == bit_jump_if_set;
    if (e.tk) e.np = e.np + sx(b2);
    go(`CAMD_M_BITR, `CAMD_C_BTJ, `CAMD_PFX_IND, e);
    end_sim();
  end
endmodule // cpu_addressing_mode_decoder_test
